// ### logic/bes_map.vh
// Purpose: constants for the erase/suspend host controller: timing, flash codes, register map
// Assumes: 100 MHz clock, byte-wide flash with 64 KB blocks
// Notes: times are in ns; cycle counts derive from them with rounding up
`ifndef BES_MAP_VH
`define BES_MAP_VH

// clock and timing, ns
`define BES_CLK_NS 10
`define BES_T_WP_NS 50
`define BES_T_WC_NS 90
`define BES_T_AA_NS 90
`define BES_T_OD_NS 20
`define BES_T_WB_NS 200
`define BES_T_RS_NS 1000
`define BES_T_RPL_NS 100
// least times round up to whole cycles
`define BES_CYC(t) (((t) + `BES_CLK_NS - 1) / `BES_CLK_NS)
// latency seen by sampled data: the two synchroniser flops plus the sampling flop
`define BES_SYNC_LAT 3

// flash command codes
`define BES_CMD_READ_ARRAY 8'hFF
`define BES_CMD_READ_STATUS 8'h70
`define BES_CMD_CLEAR_STATUS 8'h50
`define BES_CMD_ERASE_SETUP 8'h20
`define BES_CMD_ERASE_CONFIRM 8'hD0
`define BES_CMD_ERASE_SUSPEND 8'hB0

// flash status byte bit positions
`define BES_SR_READY 7
`define BES_SR_SUSP 6
`define BES_SR_ERASE_FAIL 5
`define BES_SR_PROG_FAIL 4
`define BES_SR_SUPPLY 3

// flash geometry
`define BES_AW 21
`define BES_BLK_MSB 20
`define BES_BLK_LSB 16

// controller operations written to the command register
`define BES_OP_NONE 4'h0
`define BES_OP_ERASE 4'h1
`define BES_OP_SUSPEND 4'h2
`define BES_OP_RESUME 4'h3
`define BES_OP_STATUS 4'h4
`define BES_OP_CLEAR 4'h5
`define BES_OP_READ_ARRAY 4'h6
`define BES_OP_READ 4'h7

// error decode values
`define BES_ERR_NONE 3'h0
`define BES_ERR_SUPPLY 3'h1
`define BES_ERR_PROG 3'h2
`define BES_ERR_ERASE 3'h3
`define BES_ERR_SEQ 3'h4

// register byte offsets
`define BES_REG_CMD 8'h00
`define BES_REG_ADDR 8'h04
`define BES_REG_CFG 8'h08
`define BES_REG_STAT 8'h0C
`define BES_REG_DATA 8'h10

// status register fields
`define BES_ST_BUSY 0
`define BES_ST_ERASING 1
`define BES_ST_SUSP 2
`define BES_ST_REFUSED 3
`define BES_ST_NEEDCLR 4
`define BES_ST_RDY 5
`define BES_ST_PD 6
`define BES_ST_SUSPREQ 7
`define BES_ST_ERR_LSB 8
`define BES_ST_SR_LSB 16

// config register fields and reset value
`define BES_CFG_PD 0
`define BES_CFG_RST 1'b0

`endif

// ### logic/bes_sync2.v
// Purpose: two flip-flop synchroniser for flash pin inputs
// Assumes: inputs asynchronous to CLK
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module bes_sync2 #(
   parameter W = 8
) (
   // clock and reset
   input wire clk,
   input wire reset,
   // data
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_reg;

   always @(posedge clk) begin
      if (reset) begin
         meta_reg <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// ### logic/bes_bus_cycle.v
// Purpose: one strobed flash bus cycle, write or read, with pin timing
// Assumes: requester holds req until done; a req still high after done starts the next cycle
// Notes: all pin outputs are flops; address and data held through recovery
`timescale 1ns/1ps
`include "bes_map.vh"
module bes_bus_cycle #(
   parameter AW = 21,
   parameter WP_CYC = 5,
   parameter WH_CYC = 4,
   parameter ACC_CYC = 12,
   parameter OD_CYC = 2
) (
   // clock and reset
   input wire clk,
   input wire reset,
   // request
   input wire req,
   input wire is_write,
   input wire [AW-1:0] addr,
   input wire [7:0] wdata,
   input wire [7:0] dq_sync,
   output wire done,
   output reg [7:0] rdata,
   // pins
   output reg ce_n,
   output reg we_n,
   output reg oe_n,
   output reg [AW-1:0] addr_out,
   output reg [7:0] dq_out,
   output reg dq_oe
);
   localparam ST_IDLE = 3'b001;
   localparam ST_ACT = 3'b010;
   localparam ST_REC = 3'b100;
   localparam [7:0] WP_L = WP_CYC - 1;
   localparam [7:0] WH_L = WH_CYC - 1;
   localparam [7:0] ACC_L = ACC_CYC - 1;
   localparam [7:0] OD_L = OD_CYC - 1;

   reg [2:0] state_reg;
   reg [7:0] cnt_reg;
   reg write_reg;

   assign done = (state_reg == ST_REC) && (cnt_reg == 8'h00);

   always @(posedge clk) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 8'h00;
         write_reg <= 1'b0;
         rdata <= 8'h00;
         ce_n <= 1'b1;
         we_n <= 1'b1;
         oe_n <= 1'b1;
         addr_out <= {AW{1'b0}};
         dq_out <= 8'h00;
         dq_oe <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (req) begin
                  // address and data settle with the strobe; low phase covers setup
                  addr_out <= addr;
                  dq_out <= wdata;
                  write_reg <= is_write;
                  dq_oe <= is_write;
                  ce_n <= 1'b0;
                  we_n <= ~is_write;
                  oe_n <= is_write;
                  cnt_reg <= is_write ? WP_L : ACC_L;
                  state_reg <= ST_ACT;
               end
            end
            ST_ACT: begin
               if (cnt_reg == 8'h00) begin
                  ce_n <= 1'b1;
                  we_n <= 1'b1;
                  oe_n <= 1'b1;
                  if (!write_reg) begin
                     rdata <= dq_sync;
                  end
                  cnt_reg <= write_reg ? WH_L : OD_L;
                  state_reg <= ST_REC;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            ST_REC: begin
               // data held past the rising strobe; released only at the end
               if (cnt_reg == 8'h00) begin
                  dq_oe <= 1'b0;
                  state_reg <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// ### logic/bes_host_top.v
// Purpose: APB-programmed host that drives block erase, suspend and status on a flash
// Assumes: flash pins on a byte bus; one 100 MHz clock; APB slave with no wait states
// Notes: host tracks the flash mode and refuses commands the flash must not see
`timescale 1ns/1ps
`include "bes_map.vh"

// What this block does
// - erase starts with setup code 20H, address ignored.
// - second write is confirm D0H with an address inside the block.
// - during erase only erase suspend may be written; the host also writes resume D0H once a suspend is requested.
// - in suspend only read array, resume and read status are written.
// - suspended, array reads must stay outside the erasing block.
// - keep supply and reset-powerdown unchanged through a suspend.
// - error flags valid once ready flag set; only 50H clears them; the host also clears them in reset-powerdown.
// - power-up: strobes high and reset-powerdown pulsed high-low-high; the host holds it low from reset and raises it after T_RPL_CYC cycles.
// - after a supply flag, clear status before another erase.
// - read array code FFH leaves status mode.
// - D0H also resumes a suspended erase.
// - status bit 7 is ready; host polls it for flag validity.
module bes_host_top #(
   parameter AW = `BES_AW,
   parameter T_WB_CYC = `BES_CYC(`BES_T_WB_NS),
   parameter T_RS_CYC = `BES_CYC(`BES_T_RS_NS),
   parameter T_RPL_CYC = `BES_CYC(`BES_T_RPL_NS)
) (
   // clock and reset
   input wire CLK,
   input wire RESET,
   // apb slave
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output wire PREADY,
   output wire PSLVERR,
   // flash strobes
   output wire FLASH_CE_N,
   output wire FLASH_WE_N,
   output wire FLASH_OE_N,
   output reg FLASH_RESET_POWERDOWN_N,
   input wire FLASH_READY_BUSY,
   // flash address and data pins
   output wire [AW-1:0] FLASH_ADDR,
   input wire [7:0] FLASH_DATA_I,
   output wire [7:0] FLASH_DATA_O,
   output wire FLASH_DATA_OE
);
   localparam S_IDLE = 8'b00000001;
   localparam S_W1 = 8'b00000010;
   localparam S_W2 = 8'b00000100;
   localparam S_RD = 8'b00001000;
   localparam S_WAIT = 8'b00010000;
   localparam S_PDN = 8'b00100000;
   localparam S_RPL = 8'b01000000;
   localparam S_RS = 8'b10000000;
   localparam [15:0] WB_L = T_WB_CYC - 1;
   localparam [15:0] RS_L = T_RS_CYC - 1;
   localparam [15:0] RPL_L = T_RPL_CYC - 1;

   reg [7:0] state_reg, state_next;
   reg [15:0] cnt_reg;
   reg [3:0] op_reg;
   reg [7:0] code1_reg;
   reg has2_reg, rd_after_reg, wait_after_reg;
   reg [AW-1:0] addr_reg;
   reg [4:0] erase_blk_reg;
   reg cfg_pd_reg;
   reg mode_status_reg, erasing_reg, suspended_reg, suspend_req_reg;
   reg needs_clear_reg, refused_reg;
   reg [2:0] err_reg;
   reg [7:0] srd_reg, rdata_reg;

   wire [7:0] dq_sync;
   wire rdy_sync;
   wire eng_done;
   wire [7:0] eng_rdata;
   wire eng_req = (state_reg == S_W1) || (state_reg == S_W2) || (state_reg == S_RD);
   wire eng_write = (state_reg == S_W1) || (state_reg == S_W2);
   wire [7:0] eng_wdata = (state_reg == S_W2) ? `BES_CMD_ERASE_CONFIRM : code1_reg;

   // apb decode
   wire setup = PSEL && !PENABLE;
   wire access = PSEL && PENABLE;
   wire [7:0] word_addr = {PADDR[7:2], 2'b00};
   wire hit = (word_addr == `BES_REG_CMD) || (word_addr == `BES_REG_ADDR) ||
      (word_addr == `BES_REG_CFG) || (word_addr == `BES_REG_STAT) ||
      (word_addr == `BES_REG_DATA);
   wire wr_cmd = access && PWRITE && (word_addr == `BES_REG_CMD);
   wire wr_addr = access && PWRITE && (word_addr == `BES_REG_ADDR);
   wire wr_cfg = access && PWRITE && (word_addr == `BES_REG_CFG);
   wire [3:0] new_op = PWDATA[3:0];
   wire in_block = (addr_reg[`BES_BLK_MSB:`BES_BLK_LSB] == erase_blk_reg);
   wire idle_ok = (state_reg == S_IDLE) && !cfg_pd_reg;
   wire accept = wr_cmd && idle_ok && op_allowed(new_op, erasing_reg, suspended_reg,
      suspend_req_reg, needs_clear_reg, mode_status_reg, in_block);
   // pd changes are held off while an erase is live or suspended
   wire cfg_ok = !erasing_reg;
   wire refuse = (wr_cmd && !accept) || (wr_addr && (state_reg != S_IDLE)) ||
      (wr_cfg && !cfg_ok);
   wire rd_done = (state_reg == S_RD) && eng_done;

   assign PREADY = 1'b1;
   assign PSLVERR = access && !hit;

   // which operations the flash may be given in its present mode
   function op_allowed;
      input [3:0] op;
      input erasing, susp, susp_req, need_clr, stat_mode, blk;
      begin
         case (op)
            `BES_OP_ERASE: op_allowed = !erasing && !need_clr;
            `BES_OP_SUSPEND: op_allowed = erasing && !susp && !susp_req;
            `BES_OP_RESUME: op_allowed = susp || susp_req;
            `BES_OP_STATUS: op_allowed = !erasing || susp;
            `BES_OP_CLEAR: op_allowed = !erasing;
            `BES_OP_READ_ARRAY: op_allowed = !erasing || susp;
            `BES_OP_READ: op_allowed = !(susp && !stat_mode && blk);
            default: op_allowed = 1'b0;
         endcase
      end
   endfunction

   // status flag decode, sequencing error checked first
   function [2:0] err_decode;
      input [7:0] sr;
      begin
         if (sr[`BES_SR_ERASE_FAIL] && sr[`BES_SR_PROG_FAIL] && !sr[`BES_SR_SUPPLY]) begin
            err_decode = `BES_ERR_SEQ;
         end else if (sr[`BES_SR_ERASE_FAIL]) begin
            err_decode = `BES_ERR_ERASE;
         end else if (sr[`BES_SR_PROG_FAIL]) begin
            err_decode = `BES_ERR_PROG;
         end else if (sr[`BES_SR_SUPPLY]) begin
            err_decode = `BES_ERR_SUPPLY;
         end else begin
            err_decode = `BES_ERR_NONE;
         end
      end
   endfunction

   bes_sync2 #(.W(9)) u_sync (
      .clk(CLK),
      .reset(RESET),
      .d({FLASH_READY_BUSY, FLASH_DATA_I}),
      .q({rdy_sync, dq_sync})
   );

   bes_bus_cycle #(
      .AW(AW),
      .WP_CYC(`BES_CYC(`BES_T_WP_NS)),
      .WH_CYC(`BES_CYC(`BES_T_WC_NS) - `BES_CYC(`BES_T_WP_NS)),
      .ACC_CYC(`BES_CYC(`BES_T_AA_NS) + `BES_SYNC_LAT),
      .OD_CYC(`BES_CYC(`BES_T_OD_NS))
   ) u_cycle (
      .clk(CLK),
      .reset(RESET),
      .req(eng_req),
      .is_write(eng_write),
      .addr(addr_reg),
      .wdata(eng_wdata),
      .dq_sync(dq_sync),
      .done(eng_done),
      .rdata(eng_rdata),
      .ce_n(FLASH_CE_N),
      .we_n(FLASH_WE_N),
      .oe_n(FLASH_OE_N),
      .addr_out(FLASH_ADDR),
      .dq_out(FLASH_DATA_O),
      .dq_oe(FLASH_DATA_OE)
   );

   // sequencer next state
   always @* begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            if (cfg_pd_reg) begin
               state_next = S_PDN;
            end else if (accept) begin
               state_next = (new_op == `BES_OP_READ) ? S_RD : S_W1;
            end
         end
         S_W1: begin
            if (eng_done) begin
               if (has2_reg) begin
                  state_next = S_W2;
               end else if (rd_after_reg) begin
                  state_next = S_RD;
               end else if (wait_after_reg) begin
                  state_next = S_WAIT;
               end else begin
                  state_next = S_IDLE;
               end
            end
         end
         S_W2: if (eng_done) state_next = S_WAIT;
         S_RD: if (eng_done) state_next = S_IDLE;
         S_WAIT: if (cnt_reg == 16'h0000) state_next = S_IDLE;
         S_PDN: if (!cfg_pd_reg) state_next = S_RS;
         S_RPL: if (cnt_reg == 16'h0000) state_next = S_RS;
         S_RS: if (cnt_reg == 16'h0000) state_next = S_IDLE;
         default: state_next = S_IDLE;
      endcase
   end

   // sequencer, pins and counters
   always @(posedge CLK) begin
      if (RESET) begin
         state_reg <= S_RPL;
         cnt_reg <= RPL_L;
         FLASH_RESET_POWERDOWN_N <= 1'b0;
         op_reg <= `BES_OP_NONE;
         code1_reg <= `BES_CMD_READ_ARRAY;
         has2_reg <= 1'b0;
         rd_after_reg <= 1'b0;
         wait_after_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (state_next != state_reg) begin
            case (state_next)
               S_WAIT: cnt_reg <= WB_L; // status is stale until the busy delay
               S_RS: cnt_reg <= RS_L;
               default: cnt_reg <= cnt_reg;
            endcase
         end else if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
         end
         // engine idle keeps strobes high while the pin pulses
         FLASH_RESET_POWERDOWN_N <= !(state_next == S_PDN || state_next == S_RPL);
         if (accept) begin
            op_reg <= new_op;
            has2_reg <= (new_op == `BES_OP_ERASE);
            rd_after_reg <= (new_op == `BES_OP_STATUS);
            wait_after_reg <= (new_op == `BES_OP_SUSPEND) || (new_op == `BES_OP_RESUME);
            case (new_op)
               `BES_OP_ERASE: code1_reg <= `BES_CMD_ERASE_SETUP;
               `BES_OP_SUSPEND: code1_reg <= `BES_CMD_ERASE_SUSPEND;
               `BES_OP_RESUME: code1_reg <= `BES_CMD_ERASE_CONFIRM;
               `BES_OP_STATUS: code1_reg <= `BES_CMD_READ_STATUS;
               `BES_OP_CLEAR: code1_reg <= `BES_CMD_CLEAR_STATUS;
               default: code1_reg <= `BES_CMD_READ_ARRAY;
            endcase
         end
      end
   end

   // register file and flash mode tracking
   always @(posedge CLK) begin
      if (RESET) begin
         addr_reg <= {AW{1'b0}};
         erase_blk_reg <= 5'h00;
         cfg_pd_reg <= `BES_CFG_RST;
         mode_status_reg <= 1'b0;
         erasing_reg <= 1'b0;
         suspended_reg <= 1'b0;
         suspend_req_reg <= 1'b0;
         needs_clear_reg <= 1'b0;
         refused_reg <= 1'b0;
         err_reg <= `BES_ERR_NONE;
         srd_reg <= 8'h00;
         rdata_reg <= 8'h00;
      end else begin
         if (wr_addr && (state_reg == S_IDLE)) begin
            addr_reg <= PWDATA[AW-1:0];
         end
         if (wr_cfg && cfg_ok) begin
            cfg_pd_reg <= PWDATA[`BES_CFG_PD];
         end
         // a refusal is sticky until the next accepted command
         if (refuse) begin
            refused_reg <= 1'b1;
         end else if (accept) begin
            refused_reg <= 1'b0;
         end
         if (state_reg == S_PDN || state_reg == S_RPL) begin
            // powered-down flash returns cleared and in array mode
            mode_status_reg <= 1'b0;
            needs_clear_reg <= 1'b0;
            err_reg <= `BES_ERR_NONE;
            srd_reg <= 8'h00;
         end else if (accept) begin
            case (new_op)
               `BES_OP_ERASE: begin
                  erasing_reg <= 1'b1;
                  mode_status_reg <= 1'b1;
                  erase_blk_reg <= addr_reg[`BES_BLK_MSB:`BES_BLK_LSB];
               end
               `BES_OP_SUSPEND: begin
                  suspend_req_reg <= 1'b1;
                  mode_status_reg <= 1'b1;
               end
               `BES_OP_RESUME: begin
                  suspended_reg <= 1'b0;
                  suspend_req_reg <= 1'b0;
                  mode_status_reg <= 1'b1;
               end
               `BES_OP_STATUS: mode_status_reg <= 1'b1;
               `BES_OP_CLEAR: begin
                  needs_clear_reg <= 1'b0;
                  err_reg <= `BES_ERR_NONE;
               end
               `BES_OP_READ_ARRAY: mode_status_reg <= 1'b0;
               default: mode_status_reg <= mode_status_reg;
            endcase
         end else if (rd_done) begin
            rdata_reg <= eng_rdata;
            if (mode_status_reg && eng_rdata[`BES_SR_READY]) begin
               srd_reg <= eng_rdata;
               err_reg <= err_decode(eng_rdata);
               needs_clear_reg <= eng_rdata[`BES_SR_SUPPLY];
               if (suspend_req_reg && eng_rdata[`BES_SR_SUSP]) begin
                  suspended_reg <= 1'b1;
                  suspend_req_reg <= 1'b0;
               end else if (!eng_rdata[`BES_SR_SUSP]) begin
                  // ready and not suspended: erase over, flash left in status mode
                  erasing_reg <= 1'b0;
                  suspend_req_reg <= 1'b0;
               end
            end else if (mode_status_reg) begin
               srd_reg <= eng_rdata;
            end
         end
      end
   end

   // read data registered in the setup phase
   always @(posedge CLK) begin
      if (RESET) begin
         PRDATA <= 32'h00000000;
      end else if (setup && !PWRITE) begin
         case (word_addr)
            `BES_REG_CMD: PRDATA <= {28'h0000000, op_reg};
            `BES_REG_ADDR: PRDATA <= {{(32 - AW){1'b0}}, addr_reg};
            `BES_REG_CFG: PRDATA <= {31'h00000000, cfg_pd_reg};
            `BES_REG_STAT: PRDATA <= {8'h00, srd_reg, 5'h00, err_reg, suspend_req_reg,
               (state_reg == S_PDN), rdy_sync, needs_clear_reg, refused_reg,
               suspended_reg, erasing_reg, (state_reg != S_IDLE)};
            `BES_REG_DATA: PRDATA <= {24'h000000, rdata_reg};
            default: PRDATA <= 32'h00000000;
         endcase
      end
   end
endmodule

// ### tb/bes_flash_model.sv
// Purpose: behavioural flash for the erase host bench
// Assumes: strobes are host flops, sampled on clk
// Notes: erase time counted in clk; inj forces flags at erase end
`timescale 1ns/1ps
module bes_flash_model #(
   parameter ER_CYC = 400
) (
   // clock and fault control
   input wire clk,
   input wire [1:0] inj,
   // pins
   input wire ce_n,
   input wire we_n,
   input wire oe_n,
   input wire rp_n,
   input wire [20:0] addr,
   input wire [7:0] din,
   output wire [7:0] dout,
   output wire rdy
);
   reg [7:0] sr = 8'h80;
   reg [7:0] last = 8'h00;
   reg stat = 1'b0;
   reg setup = 1'b0;
   reg sreq = 1'b0;
   reg we_q = 1'b1;
   reg [4:0] blk = 5'h00;
   reg [4:0] done_blk = 5'h1F;
   integer cnt = 0;
   wire drv = !ce_n && !oe_n && rp_n;
   wire [7:0] q = (stat || !sr[7]) ? sr : (addr[20:16] == done_blk ? 8'hFF : addr[7:0]);
   // undriven pins show the inverse of the last byte, not a held value
   assign dout = drv ? q : ~last;
   assign rdy = sr[7] || !rp_n;
   always @(posedge clk) begin
      we_q <= we_n;
      if (drv)
         last <= q;
      if (!rp_n) begin
         sr <= 8'h80;
         stat <= 1'b0;
         setup <= 1'b0;
         sreq <= 1'b0;
         cnt <= 0;
      end else if (we_n && !we_q) begin
         stat <= 1'b1;
         if (setup) begin
            setup <= 1'b0;
            if (din == 8'hD0) begin
               blk <= addr[20:16];
               cnt <= ER_CYC;
               sr[7] <= 1'b0;
            end else
               sr[5:4] <= 2'b11;
         end else case (din)
            8'h20: setup <= 1'b1;
            8'h50: sr[5:3] <= 3'b000;
            8'hFF: stat <= 1'b0;
            8'hB0: sreq <= !sr[7];
            8'hD0: begin
               sreq <= 1'b0;
               sr[6] <= 1'b0;
               sr[7] <= cnt == 0;
            end
            default: stat <= 1'b1;
         endcase
      end else if (sreq) begin
         sreq <= 1'b0;
         sr[7:6] <= 2'b11;
      end else if (cnt > 0 && !sr[6]) begin
         cnt <= cnt - 1;
         // flags OR into any left by earlier erases; only 50H or reset-powerdown clears them
         if (cnt == 1) begin
            sr[7] <= 1'b1;
            sr[5:3] <= sr[5:3] | {inj[1], 1'b0, inj[0]};
            done_blk <= blk;
         end
      end
   end
endmodule

// ### tb/bes_host_top_properties.sv
// Purpose: flash pin checks for the erase host
// Assumes: one clock, synchronous reset
// Notes: sees top ports only
`timescale 1ns/1ps
module bes_host_top_properties #(
   parameter AW = 21,
   parameter T_RPL_CYC = 10
) (
   // clock and reset
   input wire CLK,
   input wire RESET,
   // flash pins
   input wire FLASH_CE_N,
   input wire FLASH_WE_N,
   input wire FLASH_OE_N,
   input wire FLASH_RESET_POWERDOWN_N,
   input wire [AW-1:0] FLASH_ADDR,
   input wire [7:0] FLASH_DATA_O,
   input wire FLASH_DATA_OE
);
   integer low_cnt = 0;
   // held at zero in reset so an unknown pin level before reset cannot stick
   always @(posedge CLK)
      low_cnt <= (RESET || FLASH_RESET_POWERDOWN_N) ? 0 : low_cnt + 1;
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence wr_pulse;
      (!FLASH_WE_N)[*5] ##1 FLASH_WE_N;
   endsequence
   sequence setup_wr;
      $fell(FLASH_WE_N) && FLASH_DATA_O == 8'h20;
   endsequence
   sequence confirm_wr;
      $fell(FLASH_WE_N) && FLASH_DATA_O == 8'hD0;
   endsequence
   a_rp_low_width: assert property (
      $rose(FLASH_RESET_POWERDOWN_N) |-> low_cnt >= T_RPL_CYC)
      else $error("reset-powerdown pulse too short");
   a_rp_after_reset: assert property ($fell(RESET) |-> !FLASH_RESET_POWERDOWN_N)
      else $error("reset-powerdown not low after reset");
   a_pd_strobes_off: assert property (
      !FLASH_RESET_POWERDOWN_N |-> FLASH_CE_N && FLASH_WE_N)
      else $error("strobe active in power-down");
   a_write_pulse: assert property ($fell(FLASH_WE_N) |-> wr_pulse)
      else $error("write pulse width wrong");
   a_we_in_ce: assert property (
      !FLASH_WE_N |-> !FLASH_CE_N && FLASH_OE_N && FLASH_DATA_OE)
      else $error("write strobe without chip enable or data");
   a_write_hold: assert property (!FLASH_WE_N && $past(!FLASH_WE_N) |->
      $stable(FLASH_ADDR) && $stable(FLASH_DATA_O))
      else $error("address or data moved in write");
   a_read_no_drive: assert property (!FLASH_OE_N |-> !FLASH_DATA_OE && !FLASH_CE_N)
      else $error("host drives data during read");
   a_erase_pair: assert property (setup_wr |-> ##[6:20] confirm_wr)
      else $error("erase setup not followed by confirm");
endmodule
bind bes_host_top bes_host_top_properties #(.AW(AW), .T_RPL_CYC(T_RPL_CYC)) i_props (.CLK(CLK),
   .RESET(RESET), .FLASH_CE_N(FLASH_CE_N), .FLASH_WE_N(FLASH_WE_N), .FLASH_OE_N(FLASH_OE_N),
   .FLASH_RESET_POWERDOWN_N(FLASH_RESET_POWERDOWN_N), .FLASH_ADDR(FLASH_ADDR),
   .FLASH_DATA_O(FLASH_DATA_O), .FLASH_DATA_OE(FLASH_DATA_OE));

// ### tb/test_block_erase_suspend_sequencer.sv
// Purpose: bench for the erase/suspend host over apb
// Assumes: short reset and wait counts; flash model on the far side
// Notes: polls are cut short only by the cycle ceiling
`timescale 1ns/1ps
module test_block_erase_suspend_sequencer;
   reg CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, er;
   reg [7:0] PADDR = 8'h00;
   reg [31:0] PWDATA = 32'h0, rd;
   reg [1:0] inj = 2'b00;
   wire [31:0] PRDATA;
   wire PREADY, PSLVERR, ce_n, we_n, oe_n, rp_n, rdy, doe;
   wire [20:0] fa;
   wire [7:0] dto, dfl;
   integer num_errors = 0, n_tests = 0, cyc = 0;
   initial forever #5 CLK = ~CLK;
   bes_host_top #(.T_WB_CYC(2), .T_RS_CYC(2), .T_RPL_CYC(2)) i_dut (.CLK(CLK), .RESET(RESET),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FLASH_CE_N(ce_n), .FLASH_WE_N(we_n),
      .FLASH_OE_N(oe_n), .FLASH_RESET_POWERDOWN_N(rp_n), .FLASH_READY_BUSY(rdy), .FLASH_ADDR(fa),
      .FLASH_DATA_I(doe ? dto : dfl), .FLASH_DATA_O(dto), .FLASH_DATA_OE(doe));
   bes_flash_model i_flash (.clk(CLK), .inj(inj), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
      .rp_n(rp_n), .addr(fa), .din(dto), .dout(dfl), .rdy(rdy));
   task complete_run;
      begin
         if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         num_errors = num_errors + 1;
         complete_run;
      end
   end
   task chk(input [31:0] got, input [31:0] exp, input [31:0] msk);
      begin
         n_tests = n_tests + 1;
         if ((got & msk) !== (exp & msk)) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge CLK);
         PSEL <= 1;
         PENABLE <= 0;
         PWRITE <= w;
         PADDR <= a;
         PWDATA <= d;
         @(posedge CLK);
         PENABLE <= 1;
         @(posedge CLK);
         while (PREADY !== 1'b1) @(posedge CLK);
         rd = PRDATA;
         er = PSLVERR;
         PSEL <= 0;
         PENABLE <= 0;
      end
   endtask
   // leaves the status word in rd
   task op(input [3:0] c);
      begin
         if (c != 0)
            apb(1, 8'h00, {28'h0, c});
         apb(0, 8'h0C, 0);
         while (rd[0] !== 1'b0) apb(0, 8'h0C, 0);
      end
   endtask
   // a running erase takes no status command, so poll with plain reads
   task fin;
      begin
         op(7);
         while (rd[1] !== 1'b0) op(7);
      end
   endtask
   task t_erase(input [20:0] a, input [1:0] f, input [2:0] e);
      begin
         inj <= f;
         apb(1, 8'h04, {11'h0, a});
         op(1);
         fin;
         chk(rd, {8'h0, 2'b10, f[1], 1'b0, f[0], 8'h0, e, 8'h0}, 32'h00FF_0700);
      end
   endtask
   task t_susp;
      begin
         inj <= 2'b00;
         apb(1, 8'h04, 32'h0003_0000);
         op(1);
         op(2);
         while (rd[2] !== 1'b1) op(7);
         chk(rd, 32'h00C0_0024, 32'h00C0_0024);
         op(1);
         chk(rd, 32'h8, 32'h8);
         op(6);
         apb(1, 8'h04, 32'h0001_0045);
         op(7);
         apb(0, 8'h10, 0);
         chk(rd, 32'h45, 32'hFF);
         apb(1, 8'h04, 32'h0003_0010);
         op(7);
         chk(rd, 32'h8, 32'h8);
         op(3);
         fin;
         chk(rd, 32'h0080_0000, 32'h00C0_0006);
      end
   endtask
   initial begin
      repeat (10) @(posedge CLK);
      RESET <= 0;
      op(0);
      chk(rd, 0, 32'h0000_0742);
      apb(0, 8'h14, 0);
      chk({31'h0, er}, 1, 1);
      t_erase(21'h05_0123, 2'b00, 3'h0);
      op(6);
      op(7);
      apb(0, 8'h10, 0);
      chk(rd, 32'hFF, 32'hFF);
      t_erase(21'h06_0000, 2'b10, 3'h3);
      op(5);
      op(4);
      chk(rd, 32'h0080_0000, 32'h00FF_0700);
      t_erase(21'h07_0000, 2'b01, 3'h1);
      op(1);
      chk(rd, 32'h18, 32'h18);
      op(5);
      op(4);
      chk(rd, 32'h0080_0000, 32'h00FF_0710);
      t_susp;
      apb(1, 8'h08, 1);
      while (rd[6] !== 1'b1) apb(0, 8'h0C, 0);
      chk({31'h0, rp_n}, 0, 1);
      apb(1, 8'h08, 0);
      op(0);
      chk(rd, 0, 32'h00FF_0740);
      complete_run;
   end
endmodule
